// *** include/padc_pkg.sv ***
// Package of constants and types for the pipelined converter output port
// Overview of operation
// - Power-down low and output-enable-low low: convert and drive outputs.
// - Power-down low, output-enable-low high: keep converting, outputs high impedance.
// - Power-down high, output-enable-low low: nap mode, outputs high impedance.
// - Both high: sleep mode, deepest low power, outputs high impedance.
// - Result is a ten-bit word, bit 9 most significant.
// - Range flag high when input went above top or below bottom.
// - Four-level format select picks coding and stabilizer setting.
// - Result appears five clocks after its sample, one per clock.
// - Track while clock low, hold at rising edge, process while high.
// - Six stages on alternating phases, results aligned before correction.
package padc_pkg;
    localparam int WORD_W = 10;
    localparam int MSB_POS = 9;
    localparam int STAGE_NUM = 6;
    localparam int LATENCY = 5;
    localparam int FMT_W = 2;
    localparam logic [1:0] FMT_OB_DCS_OFF = 2'h0;
    localparam logic [1:0] FMT_OB_DCS_ON = 2'h1;
    localparam logic [1:0] FMT_TC_DCS_ON = 2'h2;
    localparam logic [1:0] FMT_TC_DCS_OFF = 2'h3;
    localparam logic [9:0] WORD_RESET = 10'h000;
    localparam logic [9:0] CODE_MAX = 10'h3FF;
    localparam logic [9:0] CODE_MIN = 10'h000;
    typedef enum logic [1:0] {
        PADC_NORMAL,
        PADC_HIZ,
        PADC_NAP,
        PADC_SLEEP
    } padc_mode_e;
endpackage

// *** design/padc_mode_dec.sv ***
// Power and output-enable mode decoder
module padc_mode_dec (
    input wire logic power_down_select, // Strap: power-down select
    input wire logic out_en_b, // Strap: output drive enable, active low
    output padc_pkg::padc_mode_e mode // Decoded operating mode
);
    // Decode pin-strap pair
    always_comb begin
        if (!power_down_select && !out_en_b) begin
            mode = padc_pkg::PADC_NORMAL;
        end else if (!power_down_select) begin
            mode = padc_pkg::PADC_HIZ;
        end else if (!out_en_b) begin
            mode = padc_pkg::PADC_NAP;
        end else begin
            mode = padc_pkg::PADC_SLEEP;
        end
    end
endmodule

// *** design/padc_fmt_dec.sv ***
// Output format and stabilizer decoder
module padc_fmt_dec (
    input wire logic [1:0] format_select, // Four-level select, quantised
    output logic twos_comp, // Two's complement coding
    output logic stabilizer_on // Duty-cycle stabilizer enable
);
    // Map four levels
    always_comb begin
        case (format_select)
            padc_pkg::FMT_OB_DCS_OFF: begin
                twos_comp = 1'b0;
                stabilizer_on = 1'b0;
            end
            padc_pkg::FMT_OB_DCS_ON: begin
                twos_comp = 1'b0;
                stabilizer_on = 1'b1;
            end
            padc_pkg::FMT_TC_DCS_ON: begin
                twos_comp = 1'b1;
                stabilizer_on = 1'b1;
            end
            default: begin
                twos_comp = 1'b1;
                stabilizer_on = 1'b0;
            end
        endcase
    end
endmodule

// *** design/padc_top.sv ***
// Digital side of the ten-bit pipelined converter
module padc_top (
    input wire logic clk, // Converter clock
    input wire logic rst_b, // Async reset, active low
    input wire logic power_down_select, // Power-down strap
    input wire logic out_en_b, // Output drive enable, active low
    input wire logic [1:0] format_select, // Format level 0..3
    input wire logic [9:0] analog_code, // Quantised input, offset binary
    input wire logic over_range, // Input above top of range
    input wire logic under_range, // Input below bottom of range
    output logic [9:0] sample_word, // Output word
    output logic range_exceeded_flag, // Over/under range flag
    output logic [9:0] sample_word_oe_b, // Word drive enable, low drives
    output logic range_flag_oe_b, // Flag drive enable, low drives
    output logic stabilizer_on, // Stabilizer setting
    output logic converting, // Pipeline running
    output logic nap_mode, // Nap state
    output logic sleep_mode // Sleep state
);
    typedef struct packed {
        logic [padc_pkg::LATENCY-1:0][9:0] word_pipe;
        logic [padc_pkg::LATENCY-1:0] flag_pipe;
        logic [padc_pkg::LATENCY-1:0] valid_pipe;
        logic [9:0] word_out;
        logic flag_out;
    } padc_state_s;

    padc_state_s st_reg;
    padc_state_s st_next;
    padc_pkg::padc_mode_e mode;
    logic twos_comp;
    logic run;
    logic drive;
    logic [9:0] held_code;
    logic held_flag;
    logic [9:0] corr_word;
    logic corr_flag;

    padc_mode_dec u_mode (
        .power_down_select(power_down_select),
        .out_en_b(out_en_b),
        .mode(mode)
    );

    padc_fmt_dec u_fmt (
        .format_select(format_select),
        .twos_comp(twos_comp),
        .stabilizer_on(stabilizer_on)
    );

    // Mode outputs and drive control
    always_comb begin
        // keep converting when not powered down
        run = (mode == padc_pkg::PADC_NORMAL) || (mode == padc_pkg::PADC_HIZ);
        drive = (mode == padc_pkg::PADC_NORMAL);
        nap_mode = (mode == padc_pkg::PADC_NAP);
        sleep_mode = (mode == padc_pkg::PADC_SLEEP);
        converting = run;
        sample_word_oe_b = {padc_pkg::WORD_W{!drive}};
        range_flag_oe_b = !drive;
    end

    // Sample taken at rising edge, flag from range inputs
    always_comb begin
        held_code = analog_code;
        held_flag = over_range || under_range;
        if (over_range) begin
            held_code = padc_pkg::CODE_MAX;
        end else if (under_range) begin
            held_code = padc_pkg::CODE_MIN;
        end
    end

    // Correction stage: oldest aligned result, formatted for the pins
    always_comb begin
        // last delay slot feeds the output register
        corr_word = st_reg.word_pipe[padc_pkg::LATENCY-1];
        corr_flag = st_reg.flag_pipe[padc_pkg::LATENCY-1];
        // invert top bit for two's complement
        if (twos_comp) begin
            corr_word[padc_pkg::MSB_POS] = !corr_word[padc_pkg::MSB_POS];
        end
        // Slot not yet filled since reset stays cleared
        if (!st_reg.valid_pipe[padc_pkg::LATENCY-1]) begin
            corr_word = padc_pkg::WORD_RESET;
            corr_flag = 1'b0;
        end
    end

    // Next-state: aligned stage delay line and output register
    always_comb begin
        st_next = st_reg;
        // stage results move together, frozen when stopped
        if (run) begin
            st_next.word_pipe[0] = held_code;
            st_next.flag_pipe[0] = held_flag;
            st_next.valid_pipe[0] = 1'b1;
            for (int i = 1; i < padc_pkg::LATENCY; i++) begin
                st_next.word_pipe[i] = st_reg.word_pipe[i-1];
                st_next.flag_pipe[i] = st_reg.flag_pipe[i-1];
                st_next.valid_pipe[i] = st_reg.valid_pipe[i-1];
            end
            // output loads on the fifth edge
            st_next.word_out = corr_word;
            st_next.flag_out = corr_flag;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        sample_word = st_reg.word_out;
        range_exceeded_flag = st_reg.flag_out;
    end

    property p_latency;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && !over_range && !under_range) ##1 run [*4] ##1 (run && !twos_comp)
        |=> sample_word == $past(analog_code, 6);
    endproperty
    a_latency: assert property (p_latency) else $error("word latency wrong");

    property p_flag;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && (over_range || under_range)) ##1 run [*5] |=> range_exceeded_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("range flag missing");

    property p_normal;
        @(posedge clk) disable iff (!rst_b)
        (!power_down_select && !out_en_b) |-> (sample_word_oe_b == 10'h000) && !range_flag_oe_b;
    endproperty
    a_normal: assert property (p_normal) else $error("outputs not driven");

    property p_hiz;
        @(posedge clk) disable iff (!rst_b)
        (!power_down_select && out_en_b) |-> (sample_word_oe_b == 10'h3FF) && converting;
    endproperty
    a_hiz: assert property (p_hiz) else $error("hiz mode wrong");

    property p_nap;
        @(posedge clk) disable iff (!rst_b)
        (power_down_select && !out_en_b) |-> nap_mode && range_flag_oe_b && !converting;
    endproperty
    a_nap: assert property (p_nap) else $error("nap mode wrong");

    property p_sleep;
        @(posedge clk) disable iff (!rst_b)
        (power_down_select && out_en_b) |-> sleep_mode && !nap_mode && range_flag_oe_b;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep mode wrong");

    property p_fmt;
        @(posedge clk) disable iff (!rst_b)
        stabilizer_on == (format_select == 2'h1 || format_select == 2'h2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("stabilizer select wrong");

    property p_twos;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && !over_range && !under_range) ##1 run [*4] ##1 (run && twos_comp)
        |=> sample_word == {!$past(analog_code[9], 6), $past(analog_code[8:0], 6)};
    endproperty
    a_twos: assert property (p_twos) else $error("msb not inverted");

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        !run |=> $stable(sample_word) && $stable(range_exceeded_flag);
    endproperty
    a_hold: assert property (p_hold) else $error("pipeline moved when stopped");

    // Outputs cleared while reset is held
    property p_reset;
        @(posedge clk)
        (!rst_b ##1 !rst_b) |-> (sample_word == padc_pkg::WORD_RESET) && !range_exceeded_flag;
    endproperty
    a_reset: assert property (p_reset) else $error("output not cleared in reset");

    // Normal mode runs and reports no low-power state
    property p_normal_run;
        @(posedge clk) disable iff (!rst_b)
        (!power_down_select && !out_en_b) |-> converting && !nap_mode && !sleep_mode;
    endproperty
    a_normal_run: assert property (p_normal_run) else $error("normal mode state wrong");

    // Released outputs keep flag pin undriven too
    property p_hiz_flag;
        @(posedge clk) disable iff (!rst_b)
        (!power_down_select && out_en_b) |-> range_flag_oe_b && !nap_mode && !sleep_mode;
    endproperty
    a_hiz_flag: assert property (p_hiz_flag) else $error("hiz flag drive wrong");

    // Nap releases the word pins
    property p_nap_word;
        @(posedge clk) disable iff (!rst_b)
        (power_down_select && !out_en_b) |-> (sample_word_oe_b == 10'h3FF) && !sleep_mode;
    endproperty
    a_nap_word: assert property (p_nap_word) else $error("nap word drive wrong");

    // Sleep releases the word pins and stops conversion
    property p_sleep_word;
        @(posedge clk) disable iff (!rst_b)
        (power_down_select && out_en_b) |-> (sample_word_oe_b == 10'h3FF) && !converting;
    endproperty
    a_sleep_word: assert property (p_sleep_word) else $error("sleep word drive wrong");

    // Exactly one of running, nap and sleep
    property p_mode_onehot;
        @(posedge clk) disable iff (!rst_b)
        $onehot({converting, nap_mode, sleep_mode});
    endproperty
    a_mode_onehot: assert property (p_mode_onehot) else $error("mode flags not exclusive");

    // Conversion follows the power-down strap alone
    property p_conv_pin;
        @(posedge clk) disable iff (!rst_b)
        converting == !power_down_select;
    endproperty
    a_conv_pin: assert property (p_conv_pin) else $error("converting state wrong");

    // Upper two format levels select two's complement
    property p_twos_sel;
        @(posedge clk) disable iff (!rst_b)
        twos_comp == ((format_select == padc_pkg::FMT_TC_DCS_ON)
            || (format_select == padc_pkg::FMT_TC_DCS_OFF));
    endproperty
    a_twos_sel: assert property (p_twos_sel) else $error("coding select wrong");

    // In-range sample enters the first stage unchanged
    property p_entry;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && !over_range && !under_range)
        |=> st_reg.word_pipe[0] == $past(analog_code);
    endproperty
    a_entry: assert property (p_entry) else $error("sample not held at edge");

    // First stage passes its result one slot on
    property p_pipe_shift;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run) |=> st_reg.word_pipe[1] == $past(st_reg.word_pipe[0]);
    endproperty
    a_pipe_shift: assert property (p_pipe_shift) else $error("stage alignment lost");

    // Stopped pipeline keeps every stage
    property p_stall;
        @(posedge clk) disable iff (!rst_b)
        !run |=> $stable(st_reg.word_pipe) && $stable(st_reg.flag_pipe);
    endproperty
    a_stall: assert property (p_stall) else $error("stages moved when stopped");

    // Last slot valid after five running edges
    property p_fill;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run) ##1 run [*4] |=> st_reg.valid_pipe[padc_pkg::LATENCY-1];
    endproperty
    a_fill: assert property (p_fill) else $error("pipeline fill depth wrong");

    // Over-range input clamps to full scale
    property p_clamp_hi;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && over_range) ##1 run [*4] ##1 (run && !twos_comp)
        |=> sample_word == padc_pkg::CODE_MAX;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi) else $error("over range clamp wrong");

    // Under-range input clamps to zero scale
    property p_clamp_lo;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && under_range && !over_range) ##1 run [*4] ##1 (run && !twos_comp)
        |=> sample_word == padc_pkg::CODE_MIN;
    endproperty
    a_clamp_lo: assert property (p_clamp_lo) else $error("under range clamp wrong");

    // In-range sample leaves the flag low
    property p_flag_clear;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && !over_range && !under_range) ##1 run [*5] |=> !range_exceeded_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("range flag spurious");

    // Flag unaffected by coding, top bit inverted
    property p_twos_flag;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && run && over_range) ##1 run [*4] ##1 (run && twos_comp)
        |=> range_exceeded_flag && (sample_word == 10'h1FF);
    endproperty
    a_twos_flag: assert property (p_twos_flag) else $error("coded clamp wrong");

    // Per-bit check that word and flag drivers switch together
    for (genvar gb = 0; gb < padc_pkg::WORD_W; gb++) begin : g_bit_oe
        property p_bit_oe;
            @(posedge clk) disable iff (!rst_b)
            sample_word_oe_b[gb] == range_flag_oe_b;
        endproperty
        a_bit_oe: assert property (p_bit_oe) else $error("bit enable differs");
    end
endmodule

// *** testbench/padc_capture.sv ***
// Capture logic model latching converter words
module padc_capture (
    input wire logic clk, // Converter clock
    input wire logic [9:0] word, // Sample word pins
    input wire logic flag, // Range flag pin
    output logic [9:0] cap_word, // Latched word
    output logic cap_flag // Latched flag
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk) begin
        cap_word <= word;
        cap_flag <= flag;
    end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the converter output port
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic pd = 1'b0;
    logic oe_b = 1'b0;
    logic [1:0] fmt = 2'h0;
    logic [9:0] code = 10'h000;
    logic ovr = 1'b0;
    logic und = 1'b0;
    logic [9:0] w, w_oe_b, cw;
    logic f, f_oe_b, stab, conv, nap, slp, cf;
    logic [10:0] prev;
    logic [11:0] h [0:5];
    logic [1:0] fmt_o;
    logic fresh = 1'b0;
    logic [15:0] lf = 16'h0038;
    logic [15:0] nx;
    int cnt = 0;
    int err_count = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    padc_top u_dut (.clk(clk), .rst_b(rst_b), .power_down_select(pd), .out_en_b(oe_b),
        .format_select(fmt), .analog_code(code), .over_range(ovr), .under_range(und),
        .sample_word(w), .range_exceeded_flag(f), .sample_word_oe_b(w_oe_b),
        .range_flag_oe_b(f_oe_b), .stabilizer_on(stab), .converting(conv),
        .nap_mode(nap), .sleep_mode(slp));
    padc_capture u_cap (.clk(clk), .word(w), .flag(f), .cap_word(cw), .cap_flag(cf));
    // Pseudo-random step
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected flag and word from one sample
    function automatic logic [10:0] exp_out(input logic [11:0] e, input logic [1:0] m);
        logic [9:0] v;
        v = e[11] ? 10'h3FF : (e[10] ? 10'h000 : e[9:0]);
        v[9] = v[9] ^ m[1];
        return {e[11] | e[10], v};
    endfunction
    // Compare and count
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Drive one sample at a rising edge
    task automatic step(input logic p, input logic o, input logic [1:0] m, input logic [11:0] e);
        @(posedge clk);
        pd <= p;
        oe_b <= o;
        fmt <= m;
        ovr <= e[11];
        und <= e[10];
        code <= e[9:0];
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reference pipeline, frozen while powered down
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            fresh <= 1'b0;
        end else begin
            fresh <= !pd;
            if (!pd) begin
                h[0] <= {ovr, und, code};
                for (int i = 1; i < 6; i++)
                    h[i] <= h[i-1];
                cnt <= cnt + 1;
                fmt_o <= fmt;
            end
        end
    end
    // Port checks on settled outputs
    always @(negedge clk) begin
        if (rst_b) begin
            check({f_oe_b, w_oe_b}, (pd | oe_b) ? 11'h7FF : 11'h000);
            check({8'h00, conv, nap, slp}, {8'h00, !pd, pd & !oe_b, pd & oe_b});
            check({10'h000, stab}, {10'h000, fmt[0] ^ fmt[1]});
            if (fresh && cnt >= 6)
                check({f, w}, exp_out(h[5], fmt_o));
            if (cnt >= 2)
                check({cf, cw}, prev);
            prev <= {f, w};
        end
    end
    // Corner cases, then random traffic
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 40; i++)
            step(i[5] & i[0], i[4], i[1:0], {i[3] & !i[2], i[3] & i[2],
                i[2] ? 10'h3FF : (i[4] ? 10'h200 : 10'h1FF)});
        $display("test corners done");
        for (int i = 0; i < 600; i++) begin
            lf = lfsr(lf);
            nx = lfsr(lf);
            step(lf[15:13] == 3'h0, lf[12], lf[11:10],
                {lf[9] & lf[8], lf[9] & lf[7], nx[9:0]});
            lf = nx;
        end
        $display("test random done");
        test_done();
    end
endmodule
